// ### dv/smc_cpu_model.sv
// Model of the CPU core, the wake source and the oscillator ticks.
// Assumes bench commands are one-cycle pulses on mclk.
`timescale 1ns/1ns
module smc_cpu_model (
  input  wire logic              mclk,     // System clock
  input  wire logic              rst_n,    // Sync reset, low
  input  wire logic              cmdHalt,  // Bench asks light standby
  input  wire logic              cmdStop,  // Bench asks deep standby
  input  wire logic              cmdIrq,   // Bench asks a wake event
  input  wire smc_pkg::smc_src_t srcSel,   // Clock the CPU runs on
  input  wire smc_pkg::smc_clk_t clkCtl,   // Gating from controller
  output logic                   haltReq,  // Light standby pulse
  output logic                   stopReq,  // Deep standby pulse
  output logic                   irqReq,   // Held wake request
  output smc_pkg::smc_src_t      cpuSrc,   // Current CPU clock
  output logic                   xtalTick, // Crystal period pulse
  output logic                   ringTick  // Ring period pulse
);
  logic ringDiv_q; // Ring runs at half the system rate

  // ------------------------------------------------------------
  // Oscillators
  // ------------------------------------------------------------
  assign cpuSrc   = srcSel;
  assign xtalTick = clkCtl.mainOscEn;             // Ticks only when on
  assign ringTick = clkCtl.ringOscEn & ringDiv_q; // Still when stopped

  // ------------------------------------------------------------
  // Requests
  // ------------------------------------------------------------
  // Peripherals and converter are idle here before any request
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      haltReq   <= 1'b0;
      stopReq   <= 1'b0;
      irqReq    <= 1'b0;
      ringDiv_q <= 1'b0;
    end
    else
    begin
      haltReq   <= cmdHalt;
      // Deep standby never issued on the subsystem clock
      stopReq   <= cmdStop && (srcSel != smc_pkg::SMC_SRC_SUB);
      ringDiv_q <= clkCtl.ringOscEn ? ~ringDiv_q : 1'b0;
      // Wake held until the CPU clock is back
      if (cmdIrq)
        irqReq <= 1'b1;
      else if (clkCtl.cpuClkEn)
        irqReq <= 1'b0;
    end
  end
endmodule

// ### dv/test_standby_mode_controller.sv
// Self-checking bench of the standby mode controller.
// Assumes the CPU model in smc_cpu_model drives the standby pins.
`timescale 1ns/1ns
module test_standby_mode_controller;
  logic              mclk, rst_n, avsRead, avsWrite;   // Clock, bus
  logic              cmdHalt, cmdStop, cmdIrq, optPin; // Commands
  logic [3:0]        avsAddress;                       // Bus address
  logic [31:0]       avsWriteData, avsReadData, rd;    // Bus data
  logic              avsWaitRequest, haltReq, stopReq; // Handshakes
  logic              irqReq, xtalTick, ringTick;       // Model outputs
  logic              retainHold;                       // Freeze flag
  logic [4:0]        stabStatus;                       // Progress bits
  smc_pkg::smc_src_t srcSel, cpuSrc, resumeSrc;        // Clock sources
  smc_pkg::smc_clk_t clkCtl;                           // Gating
  int                n_mismatch, tests_run, cycles;    // Counters

  smc_standby_ctrl smc_standby_ctrl_i (.mclk(mclk), .rst_n(rst_n),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .haltReq(haltReq),
    .stopReq(stopReq), .irqReq(irqReq), .cpuSrc(cpuSrc),
    .xtalTick(xtalTick), .ringTick(ringTick), .ringStopOptPin(optPin),
    .clkCtl(clkCtl), .resumeSrc(resumeSrc), .retainHold(retainHold),
    .stabStatus(stabStatus));
  smc_cpu_model smc_cpu_model_i (.mclk(mclk), .rst_n(rst_n),
    .cmdHalt(cmdHalt), .cmdStop(cmdStop), .cmdIrq(cmdIrq),
    .srcSel(srcSel), .clkCtl(clkCtl), .haltReq(haltReq),
    .stopReq(stopReq), .irqReq(irqReq), .cpuSrc(cpuSrc),
    .xtalTick(xtalTick), .ringTick(ringTick));

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Deep waits need some 64k cycles; cut a hang well after that
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Value compare
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // Cycle count compare against a window
  task automatic chkCnt(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
      n_mismatch++;
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge mclk);
    avsAddress   <= a;
    avsWriteData <= wd;
    avsWrite     <= wr;
    avsRead      <= !wr;
    @(posedge mclk);
    while (avsWaitRequest !== 1'b0)
      @(posedge mclk);
    d = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, rd);
    chkVal(rd, e);
  endtask
  // Standby request: k 0 light, 1 deep; outputs read when settled
  task automatic pulse(input int k, input smc_pkg::smc_src_t s);
    @(posedge mclk);
    srcSel  <= s;
    cmdHalt <= (k == 0);
    cmdStop <= (k == 1);
    @(posedge mclk);
    cmdHalt <= 1'b0;
    cmdStop <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Wake event; n counts edges until the CPU clock returns
  task automatic wake(output int n);
    @(posedge mclk);
    cmdIrq <= 1'b1;
    @(posedge mclk);
    cmdIrq <= 1'b0;
    n = 1;
    while (clkCtl.cpuClkEn !== 1'b1)
    begin
      @(posedge mclk);
      n++;
    end
    @(negedge mclk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_light();
    int n;
    for (int s = 0; s < 3; s++)
    begin
      pulse(0, smc_pkg::smc_src_t'(s));
      chkVal(32'(clkCtl.cpuClkEn), 32'h0);
      chkVal({29'h0, clkCtl.subOscEn, clkCtl.mainOscEn,
              clkCtl.ringOscEn}, 32'h7);
      chkVal(32'(retainHold), 32'h1);
      chkVal(32'(resumeSrc), 32'(s));
      wake(n);
      chkCnt(n, 2, 4);
      chkVal(32'(retainHold), 32'h0);
    end
  endtask
  task automatic t_deep_main();
    int n;
    logic [4:0]  prog [4] = '{5'h10, 5'h18, 5'h1C, 5'h1E};
    logic [16:0] thr  [4] = '{smc_pkg::SMC_THR_11, smc_pkg::SMC_THR_13,
                              smc_pkg::SMC_THR_14, smc_pkg::SMC_THR_15};
    for (int c = 1; c <= 4; c++)
    begin
      bus(1'b1, smc_pkg::SMC_ADDR_WSEL, 32'(c), rd);
      pulse(1, smc_pkg::SMC_SRC_MAIN);
      chkVal({29'h0, clkCtl.cpuClkEn, clkCtl.mainOscEn,
              clkCtl.periphClkEn}, 32'h0);
      chkVal(32'(retainHold), 32'h1);
      chkVal(32'(stabStatus), 32'h0);
      rdChk(smc_pkg::SMC_ADDR_STAT, 32'h0);
      rdChk(smc_pkg::SMC_ADDR_MODE, 32'h2);
      wake(n);
      chkCnt(n, int'(thr[c-1]), int'(thr[c-1]) + 8);
      rdChk(smc_pkg::SMC_ADDR_STAT, 32'(prog[c-1]));
      chkVal(32'(stabStatus), 32'(prog[c-1]));
      rdChk(smc_pkg::SMC_ADDR_WSEL, 32'(c));
    end
  endtask
  task automatic t_deep_ring();
    int n;
    @(posedge mclk);
    optPin <= 1'b1;
    bus(1'b1, smc_pkg::SMC_ADDR_WSEL, 32'h1, rd);
    bus(1'b1, smc_pkg::SMC_ADDR_CTRL, 32'h1, rd);
    pulse(1, smc_pkg::SMC_SRC_RING);
    chkVal({30'h0, clkCtl.mainOscEn, clkCtl.ringOscEn}, 32'h1);
    wake(n);
    chkCnt(n, 33, 44);
    chkVal(32'(resumeSrc), 32'(smc_pkg::SMC_SRC_RING));
    pulse(1, smc_pkg::SMC_SRC_MAIN);
    chkVal(32'(clkCtl.ringOscEn), 32'h0);
    wake(n);
    @(posedge mclk);
    optPin <= 1'b0;
    pulse(1, smc_pkg::SMC_SRC_MAIN);
    chkVal(32'(clkCtl.ringOscEn), 32'h1);
    wake(n);
  endtask
  task automatic t_light_ctrl();
    int n;
    bus(1'b1, smc_pkg::SMC_ADDR_CTRL, 32'hC2, rd);
    rdChk(smc_pkg::SMC_ADDR_CTRL, 32'hC2);
    rdChk(smc_pkg::SMC_ADDR_STAT, 32'h0);
    pulse(0, smc_pkg::SMC_SRC_MAIN);
    chkVal({29'h0, clkCtl.mainOscEn, clkCtl.periphClkEn,
            clkCtl.periphFromMain}, 32'h3);
    wake(n);
    bus(1'b1, smc_pkg::SMC_ADDR_CTRL, 32'h0, rd);
    pulse(0, smc_pkg::SMC_SRC_MAIN);
    chkVal({29'h0, clkCtl.mainOscEn, clkCtl.periphClkEn,
            clkCtl.periphFromMain}, 32'h6);
    wake(n);
  endtask
  task automatic t_refused();
    rdChk(4'h2, 32'h0);
    bus(1'b1, smc_pkg::SMC_ADDR_STAT, 32'h1F, rd);
    rdChk(smc_pkg::SMC_ADDR_STAT, 32'h0);
    bus(1'b1, smc_pkg::SMC_ADDR_MODE, 32'h1F, rd);
    rdChk(smc_pkg::SMC_ADDR_MODE, 32'h0);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, avsRead, avsWrite, cmdHalt, cmdStop, cmdIrq, optPin} = '0;
    avsAddress   = 4'h0;
    avsWriteData = 32'h00000000;
    srcSel       = smc_pkg::SMC_SRC_MAIN;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdChk(smc_pkg::SMC_ADDR_WSEL, 32'h5);
    rdChk(smc_pkg::SMC_ADDR_STAT, 32'h0);
    rdChk(smc_pkg::SMC_ADDR_MODE, 32'h8);
    t_light();
    t_deep_main();
    t_deep_ring();
    t_light_ctrl();
    t_refused();
    finish_test();
  end
endmodule

// ### inc/smc_pkg.sv
// Shared constants and types of the standby mode controller.
// Assumes one 25 MHz clock and an Avalon-MM slave with waitrequest.
package smc_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [3:0] SMC_ADDR_CTRL  = 4'h0; // Clock control bits
  localparam logic [3:0] SMC_ADDR_WSEL  = 4'h4; // Stabilization wait code
  localparam logic [3:0] SMC_ADDR_STAT  = 4'h8; // Stabilization progress
  localparam logic [3:0] SMC_ADDR_MODE  = 4'hC; // Mode and saved clock

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SMC_BIT_RING_STOP  = 0; // Ring stop in deep standby
  localparam int SMC_BIT_PERIPH_SEL = 1; // Peripheral clock from main
  localparam int SMC_BIT_MAIN_CTRL  = 6; // Main clock control
  localparam int SMC_BIT_MAIN_STOP  = 7; // Main oscillator stop
  localparam int SMC_WSEL_W         = 3; // Width of wait code
  localparam int SMC_STAT_W         = 5; // Width of progress bits
  localparam int SMC_CNT_W          = 17; // Stabilization counter width

  // ------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------
  localparam logic [2:0] SMC_WSEL_RESET = 3'h5; // Wait code after reset
  localparam logic [4:0] SMC_STAT_RESET = 5'h00; // Progress after reset
  localparam logic [4:0] SMC_RING_WAIT  = 5'h11; // 17 ring periods
  localparam logic [16:0] SMC_THR_11 = 17'h00800; // 2^11 crystal periods
  localparam logic [16:0] SMC_THR_13 = 17'h02000; // 2^13 crystal periods
  localparam logic [16:0] SMC_THR_14 = 17'h04000; // 2^14 crystal periods
  localparam logic [16:0] SMC_THR_15 = 17'h08000; // 2^15 crystal periods
  localparam logic [16:0] SMC_THR_16 = 17'h10000; // 2^16 crystal periods

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  // CPU clock source
  typedef enum logic [1:0] {SMC_SRC_MAIN, SMC_SRC_RING, SMC_SRC_SUB}
    smc_src_t;
  // Operating mode
  typedef enum logic [2:0] {SMC_RUN, SMC_LIGHT, SMC_DEEP, SMC_XWAIT,
                            SMC_RWAIT} smc_mode_t;

  // Software clock control bits
  typedef struct packed {
    logic mainOscStop;
    logic mainClkCtrl;
    logic periphSel;
    logic ringStop;
  } smc_ctrl_t;

  // Clock gating outputs toward the clock generator
  typedef struct packed {
    logic cpuClkEn;
    logic mainOscEn;
    logic ringOscEn;
    logic subOscEn;
    logic periphClkEn;
    logic periphFromMain;
  } smc_clk_t;

  // Whole state of the controller
  typedef struct packed {
    smc_mode_t        mode;
    smc_src_t         savedSrc;
    smc_ctrl_t        ctrl;
    logic [2:0]       waitSel;
    logic [4:0]       stat;
    logic [16:0]      cnt;
    logic             cntRun;
    logic [4:0]       ringCnt;
    logic             optS1;
    logic             optS2;
    logic             ack;
    logic [31:0]      rdData;
  } smc_state_t;

  localparam smc_state_t SMC_ST_RESET = '{
    mode: SMC_RUN, savedSrc: SMC_SRC_RING, ctrl: 4'h0,
    waitSel: SMC_WSEL_RESET, stat: SMC_STAT_RESET, cnt: 17'h00000,
    cntRun: 1'b0, ringCnt: 5'h00, optS1: 1'b0, optS2: 1'b0,
    ack: 1'b0, rdData: 32'h00000000};

endpackage

// ### rtl/smc_standby_ctrl.sv
// Standby mode controller: light and deep standby, release and waits.
// Assumes CPU requests, interrupt and clock ticks are on mclk; the
// factory ring option arrives on a pin and is synchronised here.
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns

// ------------------------------------------------------------
// Function
// ------------------------------------------------------------
//
// Function
// - Light standby gates CPU clock, ring and subsystem oscillators run
// - Interrupt leaves light standby at once
// - Deep standby stops the main crystal
// - Interrupt releases deep standby after wait
// - Registers and memory held during standby
// - Port latches and buffers held during standby
// - Light standby accepted from any clock
// - Deep standby on ring clock keeps ring
// - Running ring oscillator not stopped in deep unless option and stop bit set
// - Ring clock CPU waits 17 ring periods
// - Resume on clock selected at entry
// - Ring stop bit works only if option allows
// - Light standby main crystal follows stop bits
// - Peripheral clock select; stopped in deep
// - Wait code selects crystal periods, resets 05H
// - Progress bits set in order, sticky, cleared
module smc_standby_ctrl (
  input  wire logic             mclk,            // 25 MHz clock
  input  wire logic             rst_n,           // Sync reset, low
  input  wire logic [3:0]       avsAddress,      // Byte address
  input  wire logic             avsRead,         // Read request
  input  wire logic             avsWrite,        // Write request
  input  wire logic [31:0]      avsWriteData,    // Write data
  output logic      [31:0]      avsReadData,     // Read data
  output logic                  avsWaitRequest,  // Stall
  input  wire logic             haltReq,         // Light standby pulse
  input  wire logic             stopReq,         // Deep standby pulse
  input  wire logic             irqReq,          // Interrupt request
  input  wire smc_pkg::smc_src_t cpuSrc,         // Current CPU clock
  input  wire logic             xtalTick,        // One crystal period
  input  wire logic             ringTick,        // One ring period
  input  wire logic             ringStopOptPin,  // Factory option pin
  output smc_pkg::smc_clk_t     clkCtl,          // Clock gating
  output smc_pkg::smc_src_t     resumeSrc,       // Source on resume
  output logic                  retainHold,      // Freeze state, ports
  output logic [4:0]            stabStatus       // Progress bits
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Threshold of progress bit index 0..4 (2^11 upward)
  function automatic logic [16:0] stabThr(input logic [2:0] idx);
    case (idx)
      3'h0:    stabThr = smc_pkg::SMC_THR_11;
      3'h1:    stabThr = smc_pkg::SMC_THR_13;
      3'h2:    stabThr = smc_pkg::SMC_THR_14;
      3'h3:    stabThr = smc_pkg::SMC_THR_15;
      default: stabThr = smc_pkg::SMC_THR_16;
    endcase
  endfunction

  // Threshold of a wait code; prohibited codes take the longest
  function automatic logic [16:0] codeThr(input logic [2:0] code);
    if (code == 3'h0 || code > 3'h5)
    begin
      codeThr = smc_pkg::SMC_THR_16;
    end
    else
    begin
      codeThr = stabThr(code - 3'h1);
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  smc_pkg::smc_state_t q;        // Registered state
  smc_pkg::smc_state_t d;        // Next state
  logic                 busReq;  // Any bus request
  logic                 reached; // Counter at selected wait
  logic                 optOk;   // Ring stop allowed by option

  assign busReq  = avsRead | avsWrite;
  assign reached = q.cnt >= codeThr(q.waitSel);
  assign optOk   = q.optS2;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Bus slave, mode sequence and stabilization counter
  always_comb
  begin
    d = q;
    // Option pin through two flops
    d.optS1 = ringStopOptPin;
    d.optS2 = q.optS1;
    // Bus: one wait cycle, data loaded while stalled
    d.ack = busReq & ~q.ack;
    if (busReq && !q.ack)
    begin
      case (avsAddress)
        smc_pkg::SMC_ADDR_CTRL:
        begin
          d.rdData = 32'h00000000;
          d.rdData[smc_pkg::SMC_BIT_MAIN_STOP]  = q.ctrl.mainOscStop;
          d.rdData[smc_pkg::SMC_BIT_MAIN_CTRL]  = q.ctrl.mainClkCtrl;
          d.rdData[smc_pkg::SMC_BIT_PERIPH_SEL] = q.ctrl.periphSel;
          d.rdData[smc_pkg::SMC_BIT_RING_STOP]  = q.ctrl.ringStop;
        end
        smc_pkg::SMC_ADDR_WSEL: d.rdData = {29'h0, q.waitSel};
        smc_pkg::SMC_ADDR_STAT: d.rdData = {27'h0, q.stat};
        smc_pkg::SMC_ADDR_MODE: d.rdData = {27'h0, q.savedSrc, q.mode};
        default:                d.rdData = 32'h00000000; // Unmapped
      endcase
    end
    if (avsWrite && q.ack)
    begin
      case (avsAddress)
        smc_pkg::SMC_ADDR_CTRL:
        begin
          d.ctrl.mainOscStop = avsWriteData[smc_pkg::SMC_BIT_MAIN_STOP];
          d.ctrl.mainClkCtrl = avsWriteData[smc_pkg::SMC_BIT_MAIN_CTRL];
          d.ctrl.periphSel   = avsWriteData[smc_pkg::SMC_BIT_PERIPH_SEL];
          d.ctrl.ringStop    = avsWriteData[smc_pkg::SMC_BIT_RING_STOP];
        end
        smc_pkg::SMC_ADDR_WSEL:
          d.waitSel = avsWriteData[2:0];
        default:
          d.waitSel = q.waitSel; // Read-only or unmapped: ignored
      endcase
    end
    // Progress bits cleared by main stop controls
    if (q.ctrl.mainOscStop || q.ctrl.mainClkCtrl)
    begin
      d.stat = 5'h00;
    end
    // Mode sequence
    case (q.mode)
      smc_pkg::SMC_RUN:
      begin
        if (haltReq)
        begin
          d.mode     = smc_pkg::SMC_LIGHT;
          d.savedSrc = cpuSrc;
        end
        else if (stopReq && cpuSrc != smc_pkg::SMC_SRC_SUB)
        begin
          d.mode     = smc_pkg::SMC_DEEP;
          d.savedSrc = cpuSrc;
          d.cnt      = 17'h00000;
          d.cntRun   = 1'b0;
          d.stat     = 5'h00;
        end
      end
      smc_pkg::SMC_LIGHT:
      begin
        if (irqReq)
        begin
          d.mode = smc_pkg::SMC_RUN;
        end
      end
      smc_pkg::SMC_DEEP:
      begin
        if (irqReq)
        begin
          d.cnt     = 17'h00000;
          d.cntRun  = 1'b1;
          d.ringCnt = 5'h00;
          if (q.savedSrc == smc_pkg::SMC_SRC_RING)
          begin
            d.mode = smc_pkg::SMC_RWAIT;
          end
          else
          begin
            d.mode = smc_pkg::SMC_XWAIT;
          end
        end
      end
      smc_pkg::SMC_XWAIT:
      begin
        if (reached)
        begin
          d.mode = smc_pkg::SMC_RUN;
        end
      end
      smc_pkg::SMC_RWAIT:
      begin
        if (ringTick)
        begin
          d.ringCnt = q.ringCnt + 5'h01;
          if (q.ringCnt == smc_pkg::SMC_RING_WAIT - 5'h01)
          begin
            d.mode = smc_pkg::SMC_RUN;
          end
        end
      end
      default:
        d.mode = smc_pkg::SMC_RUN;
    endcase
    // Counter runs only up to the selected wait
    if (q.cntRun)
    begin
      if (reached)
      begin
        d.cntRun = 1'b0;
      end
      else if (xtalTick)
      begin
        d.cnt = q.cnt + 17'h00001;
      end
    end
    // Progress bits set from bit 4 downward, set wins
    for (int i = 0; i < 5; i++)
    begin
      if (q.cntRun && q.cnt >= stabThr(3'(i)))
      begin
        d.stat[4 - i] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Single state register, synchronous reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      q <= smc_pkg::SMC_ST_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Clock gating from registered mode and control bits
  always_comb
  begin
    clkCtl.subOscEn       = 1'b1; // Subsystem never stopped here
    clkCtl.cpuClkEn       = (q.mode == smc_pkg::SMC_RUN);
    clkCtl.periphFromMain = q.ctrl.periphSel;
    clkCtl.periphClkEn    = (q.mode != smc_pkg::SMC_DEEP);
    clkCtl.ringOscEn      = 1'b1;
    clkCtl.mainOscEn      = ~q.ctrl.mainOscStop;
    case (q.mode)
      smc_pkg::SMC_DEEP:
      begin
        clkCtl.mainOscEn = 1'b0;
        // Ring stops only with option and bit, never as CPU clock
        clkCtl.ringOscEn = ~(optOk & q.ctrl.ringStop) |
          (q.savedSrc == smc_pkg::SMC_SRC_RING);
      end
      smc_pkg::SMC_XWAIT, smc_pkg::SMC_RWAIT:
        clkCtl.mainOscEn = 1'b1;
      default:
        clkCtl.mainOscEn = ~q.ctrl.mainOscStop | q.cntRun;
    endcase
  end

  assign resumeSrc      = q.savedSrc;
  assign retainHold     = (q.mode != smc_pkg::SMC_RUN);
  assign stabStatus     = q.stat;
  assign avsReadData    = q.rdData;
  assign avsWaitRequest = busReq & ~q.ack;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_light_gate;
    @(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_LIGHT |-> !clkCtl.cpuClkEn && clkCtl.subOscEn
      && clkCtl.ringOscEn;
  endproperty
  a_light_gate: assert property (p_light_gate)
    else $error("CPU clock not gated in light standby");

  property p_light_wake;
    @(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_LIGHT && irqReq |=> clkCtl.cpuClkEn;
  endproperty
  a_light_wake: assert property (p_light_wake)
    else $error("Light standby not left next cycle");

  property p_deep_stop;
    @(posedge mclk) disable iff (!rst_n)
    haltReq == 1'b0 && stopReq && q.mode == smc_pkg::SMC_RUN &&
      cpuSrc != smc_pkg::SMC_SRC_SUB |=> !clkCtl.mainOscEn &&
      !clkCtl.periphClkEn && stabStatus == 5'h00;
  endproperty
  a_deep_stop: assert property (p_deep_stop)
    else $error("Deep standby did not stop crystal");

  property p_deep_wait;
    @(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_DEEP && irqReq &&
      q.savedSrc == smc_pkg::SMC_SRC_MAIN |=> !clkCtl.cpuClkEn [*8];
  endproperty
  a_deep_wait: assert property (p_deep_wait)
    else $error("CPU resumed without stabilization wait");

  property p_ring_keep;
    @(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_DEEP && (!optOk ||
      q.savedSrc == smc_pkg::SMC_SRC_RING) |-> clkCtl.ringOscEn;
  endproperty
  a_ring_keep: assert property (p_ring_keep)
    else $error("Ring oscillator stopped in deep standby");

  property p_ring_wait;
    @(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_RWAIT && !(ringTick &&
      q.ringCnt == smc_pkg::SMC_RING_WAIT - 5'h01) |=> !clkCtl.cpuClkEn;
  endproperty
  a_ring_wait: assert property (p_ring_wait)
    else $error("CPU started before 17 ring periods");

  property p_src_hold;
    @(posedge mclk) disable iff (!rst_n)
    retainHold && $past(retainHold) |-> $stable(resumeSrc);
  endproperty
  a_src_hold: assert property (p_src_hold)
    else $error("Resume source changed during standby");

  property p_wsel_reset;
    @(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> q.waitSel == smc_pkg::SMC_WSEL_RESET &&
      stabStatus == smc_pkg::SMC_STAT_RESET;
  endproperty
  a_wsel_reset: assert property (p_wsel_reset)
    else $error("Wrong reset values of wait code or progress");

  property p_stat_order;
    @(posedge mclk) disable iff (!rst_n)
    stabStatus inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F};
  endproperty
  a_stat_order: assert property (p_stat_order)
    else $error("Progress bits out of order");

  property p_xwait_done;
    @(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_XWAIT && reached |=> clkCtl.cpuClkEn;
  endproperty
  a_xwait_done: assert property (p_xwait_done)
    else $error("CPU not resumed after selected wait");

  c_light: cover property (@(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_LIGHT ##1 q.mode == smc_pkg::SMC_RUN);
  c_xwait: cover property (@(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_XWAIT ##1 q.mode == smc_pkg::SMC_RUN);
  c_rwait: cover property (@(posedge mclk) disable iff (!rst_n)
    q.mode == smc_pkg::SMC_RWAIT ##1 q.mode == smc_pkg::SMC_RUN);

endmodule
